/* hw/vssm_sync_status.sv */
// sync processing control, regenerated line sync, status and line counting
// assumes pins arrive asynchronously and the host uses the byte register port
`default_nettype none

// Overview of operation
// RL1: field polarity bit resets 1, inverts field output
// RL2: pll filter bit resets 0, selects raw/filtered
// RL3: source bit picks raw or regenerated for processing
// RL4: host keeps reserved bytes at their defaults
// RL5: window width in 25 ns steps rejects extraneous
// RL6: window width resets to ten, plus minus 250ns
// RL7: activity bits for line, frame, green inputs
// RL8: holdover pin activity bit, either function
// RL9: clamp input activity bit
// RL10: polarity bits for sync, holdover, clamp inputs
// RL11: extraneous pulse flag from line filter
// RL12: twelve-bit lines per frame over two bytes
// RL13: host writes first test register with BF
// RL14: host writes second test register with 00
// RL15: third test register reads fixed, ignores writes
// RL16: count captured at each frame sync edge
// RL17: status bytes read-only, continuously updated
module vssm_sync_status #(
    parameter int ACT_TIMEOUT_CYC = vssm_pkg::ACT_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic line_sync_input_0,
    input wire logic line_sync_input_1,
    input wire logic frame_sync_input_0,
    input wire logic frame_sync_input_1,
    input wire logic green_sync_input_0,
    input wire logic green_sync_input_1,
    input wire logic ext_clock_holdover_pin,
    input wire logic clamp_input,
    input wire logic input_sel,
    input wire logic sync_on_green_sel,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic pll_sync_out,
    output logic regen_line_sync,
    output logic field_out
);

    logic [7:0] pins;
    logic [7:0] pin_lvl, pin_rise, pin_fall, pin_act, pin_pol;
    logic [7:0] ctrl_q, rsv_a_q, rsv_b_q, win_q, test_one_q, test_two_q;
    logic [2:0] line_idx, frame_idx;
    logic line_pol, raw_lvl, line_lead, line_trail, frame_lead, coast_on;
    logic [15:0] win_cyc, line_cnt_q, period_q, since_sp_q;
    logic in_win, late, accept, extra, fly, regen_edge, sp_edge;
    vssm_pkg::vssm_lock_t state_q;
    logic [2:0] miss_q;
    logic [2:0] regen_cnt_q;
    logic pass_q, odd_q, extra_seen_q, extra_stat_q;
    logic [11:0] hs_cnt_q, lines_q;

    // window half-width in clock cycles, rounded up to whole cycles
    function automatic logic [15:0] win_cycles(input logic [7:0] width);
        int ns;
        ns = int'(width) * vssm_pkg::WIN_STEP_NS;
        return 16'((ns + vssm_pkg::CLK_PERIOD_NS - 1) / vssm_pkg::CLK_PERIOD_NS);
    endfunction

    // leading edge of a sync is its move into the active level
    function automatic logic lead_edge(input logic pol, input logic r, input logic f);
        return pol ? r : f;
    endfunction

    // pin order matches the activity status bit order
    assign pins = {line_sync_input_0, line_sync_input_1, frame_sync_input_0,
                   frame_sync_input_1, green_sync_input_0, green_sync_input_1,
                   ext_clock_holdover_pin, clamp_input};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_mon
            vssm_input_monitor #(
                .TIMEOUT_CYC(ACT_TIMEOUT_CYC)
            ) u_mon (
                .ref_clk(ref_clk),
                .reset(reset),
                .pin(pins[gi]),
                .level(pin_lvl[gi]),
                .rise(pin_rise[gi]),
                .fall(pin_fall[gi]),
                .active(pin_act[gi]),
                .polarity(pin_pol[gi])
            );
        end
    endgenerate

    // active input choice; green sync is taken as negative going
    always_comb
    begin
        if (sync_on_green_sel)
            line_idx = input_sel ? vssm_pkg::IDX_GREEN_1 : vssm_pkg::IDX_GREEN_0;
        else
            line_idx = input_sel ? vssm_pkg::IDX_LINE_1 : vssm_pkg::IDX_LINE_0;
        frame_idx = input_sel ? vssm_pkg::IDX_FRAME_1 : vssm_pkg::IDX_FRAME_0;
        line_pol = sync_on_green_sel ? 1'b0 : pin_pol[line_idx];
        raw_lvl = pin_lvl[line_idx];
        line_lead = lead_edge(line_pol, pin_rise[line_idx], pin_fall[line_idx]);
        line_trail = lead_edge(!line_pol, pin_rise[line_idx], pin_fall[line_idx]);
        frame_lead = lead_edge(pin_pol[frame_idx], pin_rise[frame_idx], pin_fall[frame_idx]);
        coast_on = pin_act[vssm_pkg::IDX_HOLDOVER] &&
                   (pin_lvl[vssm_pkg::IDX_HOLDOVER] == pin_pol[vssm_pkg::IDX_HOLDOVER]);
    end

    // acceptance window around the predicted leading edge
    always_comb
    begin
        win_cyc = win_cycles(win_q); // RL5
        in_win = ({1'b0, line_cnt_q} + {1'b0, win_cyc} >= {1'b0, period_q}) &&
                 ({1'b0, line_cnt_q} <= {1'b0, period_q} + {1'b0, win_cyc}); // RL5
        late = ({1'b0, line_cnt_q} > {1'b0, period_q} + {1'b0, win_cyc});
        accept = line_lead && ((state_q == vssm_pkg::VSSM_SEEK) || in_win);
        extra = line_lead && (state_q == vssm_pkg::VSSM_LOCKED) && !in_win && !coast_on; // RL11
        fly = (state_q == vssm_pkg::VSSM_LOCKED) && late && !accept;
        regen_edge = accept || fly;
        sp_edge = ctrl_q[vssm_pkg::BIT_SYNC_PROC_SRC] ? regen_edge : line_lead; // RL3
    end

    // register writes; status, count and third test bytes take none
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctrl_q <= vssm_pkg::RESET_SYNC_PROC_CONTROL; // RL1 RL2
            rsv_a_q <= vssm_pkg::RESET_RESERVED_DEFAULT_A;
            rsv_b_q <= vssm_pkg::RESET_RESERVED_DEFAULT_B;
            win_q <= vssm_pkg::RESET_SYNC_WINDOW_WIDTH; // RL6
            test_one_q <= vssm_pkg::RESET_TEST_REG_ONE;
            test_two_q <= vssm_pkg::RESET_TEST_REG_TWO;
        end
        else if (reg_write)
        begin
            if (reg_addr == vssm_pkg::OFF_SYNC_PROC_CONTROL)
                ctrl_q <= reg_wdata;
            else if (reg_addr == vssm_pkg::OFF_RESERVED_DEFAULT_A)
                rsv_a_q <= reg_wdata;
            else if (reg_addr == vssm_pkg::OFF_RESERVED_DEFAULT_B)
                rsv_b_q <= reg_wdata;
            else if (reg_addr == vssm_pkg::OFF_SYNC_WINDOW_WIDTH)
                win_q <= reg_wdata;
            else if (reg_addr == vssm_pkg::OFF_TEST_REG_ONE)
                test_one_q <= reg_wdata;
            else if (reg_addr == vssm_pkg::OFF_TEST_REG_TWO)
                test_two_q <= reg_wdata;
        end
    end

    // read data one cycle after the address; status bytes are live
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= vssm_pkg::VALUE_UNMAPPED;
        else if (reg_addr == vssm_pkg::OFF_SYNC_PROC_CONTROL)
            reg_rdata <= ctrl_q;
        else if (reg_addr == vssm_pkg::OFF_RESERVED_DEFAULT_A)
            reg_rdata <= rsv_a_q;
        else if (reg_addr == vssm_pkg::OFF_RESERVED_DEFAULT_B)
            reg_rdata <= rsv_b_q;
        else if (reg_addr == vssm_pkg::OFF_SYNC_WINDOW_WIDTH)
            reg_rdata <= win_q;
        else if (reg_addr == vssm_pkg::OFF_INPUT_ACTIVITY_STATUS)
            reg_rdata <= pin_act; // RL7 RL8 RL9 RL17
        else if (reg_addr == vssm_pkg::OFF_INPUT_POLARITY_STATUS)
            reg_rdata <= {pin_pol[7:4], pin_pol[vssm_pkg::IDX_HOLDOVER],
                          pin_pol[vssm_pkg::IDX_CLAMP], extra_stat_q, 1'b0}; // RL10 RL11 RL17
        else if (reg_addr == vssm_pkg::OFF_LINES_PER_FRAME_HIGH)
            reg_rdata <= lines_q[11:4]; // RL12
        else if (reg_addr == vssm_pkg::OFF_LINES_PER_FRAME_LOW)
            reg_rdata <= {lines_q[3:0], 4'h0}; // RL12
        else if (reg_addr == vssm_pkg::OFF_TEST_REG_ONE)
            reg_rdata <= test_one_q;
        else if (reg_addr == vssm_pkg::OFF_TEST_REG_TWO)
            reg_rdata <= test_two_q;
        else if (reg_addr == vssm_pkg::OFF_TEST_REG_THREE)
            reg_rdata <= vssm_pkg::VALUE_TEST_REG_THREE; // RL15
        else
            reg_rdata <= vssm_pkg::VALUE_UNMAPPED;
    end

    // lock tracking; while locked, holdover freezes the period so a gap does not retrain it
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= vssm_pkg::VSSM_SEEK;
            period_q <= 16'h0000;
            miss_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                vssm_pkg::VSSM_SEEK:
                begin
                    miss_q <= 3'h0;
                    if (line_lead && line_cnt_q != 16'h0000)
                    begin
                        period_q <= line_cnt_q;
                        state_q <= vssm_pkg::VSSM_LOCKED;
                    end
                end
                vssm_pkg::VSSM_LOCKED:
                begin
                    if (!pin_act[line_idx] || miss_q >= vssm_pkg::MISS_LIMIT)
                        state_q <= vssm_pkg::VSSM_SEEK;
                    if (accept)
                    begin
                        miss_q <= 3'h0;
                        if (!coast_on)
                            period_q <= line_cnt_q;
                    end
                    else if (fly && !coast_on)
                        miss_q <= miss_q + 3'h1;
                end
                default: state_q <= vssm_pkg::VSSM_SEEK;
            endcase
        end
    end

    // cycles since the last regenerated edge, saturating
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            line_cnt_q <= 16'h0000;
        else if (regen_edge)
            line_cnt_q <= 16'h0000;
        else if (line_cnt_q != 16'hFFFF)
            line_cnt_q <= line_cnt_q + 16'h0001;
    end

    // fixed-width regenerated pulse and the gate that forms the filtered sync
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            regen_cnt_q <= 3'h0;
            regen_line_sync <= 1'b0;
            pass_q <= 1'b0;
            pll_sync_out <= 1'b0;
        end
        else
        begin
            if (regen_edge)
                regen_cnt_q <= 3'(vssm_pkg::REGEN_PULSE_CYC);
            else if (regen_cnt_q != 3'h0)
                regen_cnt_q <= regen_cnt_q - 3'h1;
            regen_line_sync <= regen_edge || (regen_cnt_q > 3'h1);
            if (accept)
                pass_q <= 1'b1;
            else if (line_trail)
                pass_q <= 1'b0;
            // rejected pulses show as the idle level on the filtered path
            if (ctrl_q[vssm_pkg::BIT_PLL_FILTER_SEL])
                pll_sync_out <= (pass_q || accept) ? raw_lvl : !line_pol; // RL2
            else
                pll_sync_out <= raw_lvl; // RL2
        end
    end

    // lines per frame: the running count is latched at each frame leading edge
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            hs_cnt_q <= 12'h000;
            lines_q <= 12'h000;
        end
        else if (frame_lead)
        begin
            lines_q <= hs_cnt_q; // RL16 RL12
            hs_cnt_q <= sp_edge ? 12'h001 : 12'h000;
        end
        else if (sp_edge && hs_cnt_q != 12'hFFF)
            hs_cnt_q <= hs_cnt_q + 12'h001; // RL3
    end

    // field parity from where the frame edge falls within the line
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            since_sp_q <= 16'h0000;
            odd_q <= 1'b0;
            field_out <= 1'b0;
        end
        else
        begin
            if (sp_edge)
                since_sp_q <= 16'h0000;
            else if (since_sp_q != 16'hFFFF)
                since_sp_q <= since_sp_q + 16'h0001;
            if (frame_lead)
                odd_q <= (since_sp_q > (period_q >> 1)); // RL3
            field_out <= odd_q ^ ctrl_q[vssm_pkg::BIT_FIELD_POLARITY]; // RL1
        end
    end

    // extraneous flag shows whether the last whole frame held any; set wins
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            extra_seen_q <= 1'b0;
            extra_stat_q <= 1'b0;
        end
        else if (frame_lead)
        begin
            extra_stat_q <= extra_seen_q || extra; // RL11
            extra_seen_q <= extra;
        end
        else if (extra)
            extra_seen_q <= 1'b1; // RL11
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_field_polarity;
        $stable(odd_q) && $stable(ctrl_q) |=> field_out == ($past(odd_q) ^ $past(ctrl_q[3]));
    endproperty
    a_field_polarity: assert property (p_field_polarity) // RL1
        else $error("field output polarity wrong");

    property p_pll_raw;
        !ctrl_q[2] |=> pll_sync_out == $past(raw_lvl);
    endproperty
    a_pll_raw: assert property (p_pll_raw) // RL2
        else $error("raw sync not routed to pll output");

    property p_sp_regen_count;
        ctrl_q[1] && regen_edge && !frame_lead && hs_cnt_q != 12'hFFF
            |=> hs_cnt_q == $past(hs_cnt_q) + 12'h001;
    endproperty
    a_sp_regen_count: assert property (p_sp_regen_count) // RL3
        else $error("regenerated edge not counted");

    property p_extra_flag;
        extra && !frame_lead ##1 frame_lead |=> extra_stat_q;
    endproperty
    a_extra_flag: assert property (p_extra_flag) // RL11
        else $error("extraneous pulse not reported");

    property p_window_reset;
        $fell(reset) |-> win_q == 8'h0A && ctrl_q == 8'h08;
    endproperty
    a_window_reset: assert property (p_window_reset) // RL6
        else $error("window or control reset value wrong");

    property p_activity_read;
        reg_addr == 8'h24 |=> reg_rdata == $past(pin_act);
    endproperty
    a_activity_read: assert property (p_activity_read) // RL7
        else $error("activity status read mismatch");

    property p_polarity_read;
        reg_addr == 8'h25 |=> reg_rdata[7:2] == $past({pin_pol[7:4], pin_pol[1:0]});
    endproperty
    a_polarity_read: assert property (p_polarity_read) // RL10
        else $error("polarity status read mismatch");

    property p_count_capture;
        frame_lead |=> lines_q == $past(hs_cnt_q) ##1 $stable(lines_q) || frame_lead;
    endproperty
    a_count_capture: assert property (p_count_capture) // RL16
        else $error("line count not captured at frame edge");

    property p_test_three;
        reg_addr == 8'h2A |=> reg_rdata == 8'h00;
    endproperty
    a_test_three: assert property (p_test_three) // RL15
        else $error("third test register not fixed");

    property p_status_ro;
        reg_write && (reg_addr == 8'h24 || reg_addr == 8'h25)
            |=> $stable(ctrl_q) && $stable(win_q) && $stable(test_one_q);
    endproperty
    a_status_ro: assert property (p_status_ro) // RL17
        else $error("write to status byte changed state");

    property p_regen_width;
        $rose(regen_line_sync) && !regen_edge ##1 !regen_edge [*4] |-> regen_line_sync;
    endproperty
    a_regen_width: assert property (p_regen_width) // RL3
        else $error("regenerated pulse too short");

endmodule

`default_nettype wire

/* hw/vssm_pkg.sv */
// constants shared by the sync status monitor and its per-pin input monitor
// assumes a single 10 MHz reference clock and a simple byte-wide register port
`default_nettype none

package vssm_pkg;

    // register byte addresses
    localparam logic [7:0] OFF_SYNC_PROC_CONTROL = 8'h20;
    localparam logic [7:0] OFF_RESERVED_DEFAULT_A = 8'h21;
    localparam logic [7:0] OFF_RESERVED_DEFAULT_B = 8'h22;
    localparam logic [7:0] OFF_SYNC_WINDOW_WIDTH = 8'h23;
    localparam logic [7:0] OFF_INPUT_ACTIVITY_STATUS = 8'h24;
    localparam logic [7:0] OFF_INPUT_POLARITY_STATUS = 8'h25;
    localparam logic [7:0] OFF_LINES_PER_FRAME_HIGH = 8'h26;
    localparam logic [7:0] OFF_LINES_PER_FRAME_LOW = 8'h27;
    localparam logic [7:0] OFF_TEST_REG_ONE = 8'h28;
    localparam logic [7:0] OFF_TEST_REG_TWO = 8'h29;
    localparam logic [7:0] OFF_TEST_REG_THREE = 8'h2A;

    // control byte fields
    localparam int BIT_FIELD_POLARITY = 3;
    localparam int BIT_PLL_FILTER_SEL = 2;
    localparam int BIT_SYNC_PROC_SRC = 1;

    // reset values
    localparam logic [7:0] RESET_SYNC_PROC_CONTROL = 8'h08;
    localparam logic [7:0] RESET_RESERVED_DEFAULT_A = 8'h00;
    localparam logic [7:0] RESET_RESERVED_DEFAULT_B = 8'h00;
    localparam logic [7:0] RESET_SYNC_WINDOW_WIDTH = 8'h0A;
    localparam logic [7:0] RESET_TEST_REG_ONE = 8'h00;
    localparam logic [7:0] RESET_TEST_REG_TWO = 8'h00;
    localparam logic [7:0] VALUE_TEST_REG_THREE = 8'h00;
    localparam logic [7:0] VALUE_UNMAPPED = 8'h00;

    // monitored pin index, equal to its activity status bit position
    localparam logic [2:0] IDX_LINE_0 = 3'h7;
    localparam logic [2:0] IDX_LINE_1 = 3'h6;
    localparam logic [2:0] IDX_FRAME_0 = 3'h5;
    localparam logic [2:0] IDX_FRAME_1 = 3'h4;
    localparam logic [2:0] IDX_GREEN_0 = 3'h3;
    localparam logic [2:0] IDX_GREEN_1 = 3'h2;
    localparam logic [2:0] IDX_HOLDOVER = 3'h1;
    localparam logic [2:0] IDX_CLAMP = 3'h0;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WIN_STEP_NS = 25;
    localparam int ACT_TIMEOUT_MS = 40;
    localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int REGEN_PULSE_NS = 500;
    localparam int REGEN_PULSE_CYC = (REGEN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MISS_LIMIT = 3'h4;

    // line regenerator lock state
    typedef enum logic {
        VSSM_SEEK = 1'b0,
        VSSM_LOCKED = 1'b1
    } vssm_lock_t;

endpackage

`default_nettype wire

/* hw/vssm_input_monitor.sv */
// one monitored sync pin: synchroniser, edge pulses, activity and polarity
// assumes an asynchronous pin and a synchronous active-high reset
`default_nettype none

module vssm_input_monitor #(
    parameter int TIMEOUT_CYC = vssm_pkg::ACT_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall,
    output logic active,
    output logic polarity
);

    logic s1_q, s2_q, s3_q;
    logic [19:0] run_q;
    logic [19:0] high_len_q;
    logic [19:0] low_len_q;
    logic seen_q;
    logic primed_q;
    logic change;

    // three stages; a change counts only once the last two agree
    always_ff @(posedge ref_clk)
    begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    assign change = (s2_q == s3_q) && (s3_q != level);

    // filtered level with one-cycle edge pulses; the first settled level after reset
    // is taken silently, so an idle-high pin does not show a false edge
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
            primed_q <= 1'b0;
        end
        else if (!primed_q)
        begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (s2_q == s3_q)
            begin
                level <= s3_q;
                primed_q <= 1'b1;
            end
        end
        else
        begin
            rise <= change && s3_q;
            fall <= change && !s3_q;
            if (change)
                level <= s3_q;
        end
    end

    // run length since the last edge, saturating so a stuck pin never wraps
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            run_q <= 20'h00000;
            high_len_q <= 20'h00000;
            low_len_q <= 20'h00000;
            seen_q <= 1'b0;
        end
        else if (rise || fall)
        begin
            run_q <= 20'h00000;
            seen_q <= 1'b1;
            if (rise)
                low_len_q <= run_q;
            else
                high_len_q <= run_q;
        end
        else if (run_q != 20'hFFFFF)
        begin
            run_q <= run_q + 20'h00001;
        end
    end

    // toggling within the timeout is activity; a short high phase means positive
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            active <= 1'b0;
            polarity <= 1'b0;
        end
        else
        begin
            active <= seen_q && (run_q < 20'(TIMEOUT_CYC));
            polarity <= (high_len_q < low_len_q);
        end
    end

endmodule

`default_nettype wire

/* tb/vssm_sync_source.sv */
// video source model: line, frame and clamp pulses on the monitor's sync pins
// assumes the bench clock; the pins move only just after a rising edge
`default_nettype none

module vssm_sync_source #(
    parameter int LINE_CYC = 40,
    parameter int LINES = 21
) (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic extra,
    output logic line_sync,
    output logic frame_sync,
    output logic clamp
);
    timeunit 1ns;
    timeprecision 100ps;

    int pos = 0;
    int line = 0;

    // raster position, parked at zero while stopped so every pin sits static
    always @(posedge ref_clk)
    begin
        if (!run)
        begin
            pos <= 0;
            line <= 0;
        end
        else if (pos == LINE_CYC - 1)
        begin
            pos <= 0;
            line <= (line == LINES - 1) ? 0 : line + 1;
        end
        else
            pos <= pos + 1;
    end

    // negative line pulse; the extra mid-line pulse lies far outside any sane window
    assign line_sync = !(run && (pos < 4 || (extra && pos >= 20 && pos < 24)));
    // one line of positive frame pulse, led 30 cycles into a line so it never meets a line edge
    assign frame_sync = run && ((line == 10 && pos >= 30) || (line == 11 && pos < 30));
    assign clamp = run && pos >= 6 && pos < 10;
endmodule

`default_nettype wire

/* tb/vssm_sync_status_tb_top.sv */
// bench for the sync status monitor: register reads and writes against a sync source
// assumes the byte register port and a small activity timeout for short runs
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module vssm_sync_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_write = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic pll_sync_out;
    logic regen_line_sync;
    logic field_out;
    logic run = 1'b0;
    logic extra = 1'b0;
    logic hold_run = 1'b0;
    logic hold_pin = 1'b0;
    logic input_sel = 1'b0;
    logic sog_sel = 1'b0;
    logic [3:0] hold_cnt = 4'h0;
    logic line_sync;
    logic frame_sync;
    logic clamp;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    int pll_lo = 0;
    int regen_hi = 0;

    always #50 ref_clk = ~ref_clk;

    vssm_sync_source u_vssm_sync_source (.ref_clk(ref_clk), .run(run), .extra(extra),
        .line_sync(line_sync), .frame_sync(frame_sync), .clamp(clamp));

    vssm_sync_status #(.ACT_TIMEOUT_CYC(2000)) u_vssm_sync_status (
        .ref_clk(ref_clk), .reset(reset),
        .line_sync_input_0(line_sync), .line_sync_input_1(line_sync),
        .frame_sync_input_0(frame_sync), .frame_sync_input_1(frame_sync),
        .green_sync_input_0(line_sync), .green_sync_input_1(line_sync),
        .ext_clock_holdover_pin(hold_pin), .clamp_input(clamp),
        .input_sel(input_sel), .sync_on_green_sel(sog_sel),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pll_sync_out(pll_sync_out),
        .regen_line_sync(regen_line_sync), .field_out(field_out));

    // short positive holdover pulses, high 2 of every 10 cycles
    always @(posedge ref_clk)
    begin
        hold_cnt <= (hold_cnt == 4'h9) ? 4'h0 : hold_cnt + 4'h1;
        hold_pin <= hold_run && (hold_cnt < 4'h2);
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hang is cut short well past the longest expected sequence
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 15000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // read data is registered, so it is valid one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge ref_clk);
        reg_addr <= a;
        @(posedge ref_clk);
        #1;
        `CHK("reg_rdata", e & m, reg_rdata & m)
    endtask

    // low cycles of the pll output and high cycles of the regenerated sync over ten lines
    task automatic measure(output int lo, output int hi);
        lo = 0;
        hi = 0;
        repeat (400)
        begin
            @(posedge ref_clk);
            #1;
            lo += int'(!pll_sync_out);
            hi += int'(regen_line_sync);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("pll_sync_out", 1'b1, pll_sync_out)
        `CHK("field_out", 1'b1, field_out)
        rd(8'h20, 8'h08, 8'hFF);
        rd(8'h21, 8'h00, 8'hFF);
        rd(8'h22, 8'h00, 8'hFF);
        rd(8'h23, 8'h0A, 8'hFF);
        rd(8'h24, 8'h00, 8'hFF);
        rd(8'h2A, 8'h00, 8'hFF);
        rd(8'h3F, 8'h00, 8'hFF);
        wr(8'h28, 8'hBF);
        wr(8'h29, 8'h00);
        rd(8'h28, 8'hBF, 8'hFF);
        wr(8'h23, 8'h14);
        rd(8'h23, 8'h14, 8'hFF);
        wr(8'h2A, 8'h55);
        rd(8'h2A, 8'h00, 8'hFF);
        // start the source with every pin toggling, 21 lines a frame
        run <= 1'b1;
        hold_run <= 1'b1;
        repeat (2600) @(posedge ref_clk);
        rd(8'h24, 8'hFF, 8'hFF);
        rd(8'h25, 8'h3C, 8'hFC);
        rd(8'h26, 8'h01, 8'hFF);
        rd(8'h27, 8'h50, 8'hFF);
        wr(8'h24, 8'h00);
        rd(8'h24, 8'hFF, 8'hFF);
        hold_run <= 1'b0;
        repeat (2600) @(posedge ref_clk);
        rd(8'h24, 8'hFD, 8'hFF);
        // regenerated sync for processing, then extra pulses once locked
        wr(8'h20, 8'h0A);
        repeat (900) @(posedge ref_clk);
        extra <= 1'b1;
        repeat (2600) @(posedge ref_clk);
        rd(8'h26, 8'h01, 8'hFF);
        rd(8'h27, 8'h50, 8'hFF);
        rd(8'h25, 8'h02, 8'h02);
        `CHK("field_out", 1'b0, field_out)
        // raw path shows both pulses, regenerated sync is 5 of every 40 cycles
        measure(pll_lo, regen_hi);
        `CHK("pll_lo_raw", 80, pll_lo)
        `CHK("regen_hi", 50, regen_hi)
        // filtered path drops the mid-line pulse
        wr(8'h20, 8'h0E);
        measure(pll_lo, regen_hi);
        `CHK("pll_lo_filt", 40, pll_lo)
        wr(8'h20, 8'h02);
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("field_out", 1'b1, field_out)
        complete_run();
    end
endmodule

`default_nettype wire
